// ---- src/dmm_pkg.sv ----
// ==========================================================
// shared constants for the data memory window mapper
// ==========================================================
package dmm_pkg;

  // ==========================================================
  // widths
  // ==========================================================
  // full data address width
  localparam int ADDR_W = 12;
  // operand and data byte width
  localparam int BYTE_W = 8;
  // bank number width
  localparam int BANK_W = 4;
  // banks in the full data space
  localparam int NUM_BANKS = 16;

  // ==========================================================
  // fast window layout
  // ==========================================================
  // first window offset that lands in the top bank
  localparam logic [7:0] FAST_SPLIT = 8'h60;
  // bank used by window offsets below the split
  localparam logic [3:0] FAST_LOW_BANK = 4'h0;
  // bank used by window offsets at or above the split
  localparam logic [3:0] FAST_HIGH_BANK = 4'hF;

  // ==========================================================
  // data memory layout
  // ==========================================================
  // first general ram address
  localparam logic [11:0] RAM_BASE = 12'h000;
  // lowest special function register address
  localparam logic [11:0] REG_AREA_BASE = 12'hEF4;
  // general ram depth, everything below the register area
  localparam int RAM_DEPTH = 3828;
  // address of the bank pointer register
  localparam logic [11:0] BANK_PTR_ADDR = 12'hFE0;

  // ==========================================================
  // reset values
  // ==========================================================
  // bank pointer after reset
  localparam logic [3:0] BANK_RESET = 4'h0;
  // address output after reset
  localparam logic [11:0] ADDR_RESET = 12'h000;
  // read data after reset
  localparam logic [7:0] DATA_RESET = 8'h00;
  // value returned by unimplemented locations
  localparam logic [7:0] DATA_ZERO = 8'h00;

  // ==========================================================
  // state of the mapper
  // ==========================================================
  typedef struct packed {
    logic [3:0] bank;     // bank pointer, low nibble only
    logic [11:0] addr;    // address of the last access
    logic [7:0] rd_data;  // byte returned by the last access
    logic done;           // one-cycle completion pulse
  } dmm_state_s;

  // ==========================================================
  // decoding shared by read and write paths
  // ==========================================================
  // true for the special function register area
  function automatic logic in_reg_area(input logic [11:0] a);
    in_reg_area = (a >= REG_AREA_BASE);
  endfunction

endpackage

// ---- src/dmm_addr_form.sv ----
// ==========================================================
// combinational data address former
// ==========================================================
module dmm_addr_form (
  input wire logic [7:0] oper,
  input wire logic win_sel,
  input wire logic [3:0] bank,
  input wire logic full_move,
  input wire logic [11:0] full_addr,
  input wire logic ext_en,
  input wire logic [11:0] alt_addr,
  output logic [11:0] addr
);

  // ==========================================================
  // address selection
  // ==========================================================
  // purely combinational so the address is ready in the operand's cycle
  always_comb
  begin
    if (full_move)
    begin
      // complete address from the encoding, bank pointer unused
      addr = full_addr;
    end
    else if (win_sel)
    begin
      // banked: pointer on top, operand below
      addr = {bank, oper};
    end
    else if (ext_en)
    begin
      // altered window comes from the indexed logic elsewhere
      addr = alt_addr;
    end
    else if (oper < dmm_pkg::FAST_SPLIT)
    begin
      // low part of window: start of bank 0, pointer ignored
      addr = {dmm_pkg::FAST_LOW_BANK, oper};
    end
    else
    begin
      // high part of window: end of bank 15, one linear space
      addr = {dmm_pkg::FAST_HIGH_BANK, oper};
    end
  end

endmodule

// ---- src/dmm_window_mapper.sv ----
module dmm_window_mapper #(
  parameter int IMPL_BANKS = dmm_pkg::NUM_BANKS
) (
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic [7:0] OPER_ADDR,
  input wire logic WIN_SEL,
  input wire logic FULL_MOVE,
  input wire logic [11:0] FULL_ADDR,
  input wire logic EXT_SET_EN,
  input wire logic [11:0] ALT_ADDR,
  input wire logic RD_REQ,
  input wire logic WR_REQ,
  input wire logic [7:0] WR_DATA,
  output logic [11:0] ADDR_OUT,
  output logic [7:0] RD_DATA,
  output logic DONE,
  output logic [3:0] BANK
);

  // ==========================================================
  // declarations
  // ==========================================================
  // registered state and its next value
  dmm_pkg::dmm_state_s st;
  dmm_pkg::dmm_state_s next_st;
  // address for the access in this cycle
  logic [11:0] eff_addr;
  // any access this cycle
  logic req;
  // byte the current address yields
  logic [7:0] rd_value;
  // write lands in general ram
  logic ram_we;
  // general ram, no reset on purpose
  logic [7:0] ram_mem [0:dmm_pkg::RAM_DEPTH-1];

  // ==========================================================
  // helpers
  // ==========================================================
  // bank exists in this build; the register area always exists
  function automatic logic bank_impl(input logic [11:0] a);
    bank_impl = ({1'b0, a[11:8]} < 5'(IMPL_BANKS));
  endfunction

  // request from either direction
  assign req = RD_REQ | WR_REQ;

  // ==========================================================
  // address former
  // ==========================================================
  dmm_addr_form u_form (
    .oper(OPER_ADDR),
    .win_sel(WIN_SEL),
    .bank(st.bank),
    .full_move(FULL_MOVE),
    .full_addr(FULL_ADDR),
    .ext_en(EXT_SET_EN),
    .alt_addr(ALT_ADDR),
    .addr(eff_addr)
  );

  // ==========================================================
  // read decode
  // ==========================================================
  // read value chosen by area; ram read is asynchronous
  always_comb
  begin
    if (dmm_pkg::in_reg_area(eff_addr))
    begin
      if (eff_addr == dmm_pkg::BANK_PTR_ADDR)
      begin
        // upper nibble of the pointer reads zero
        rd_value = {4'h0, st.bank};
      end
      else
      begin
        // peripheral registers live elsewhere, read zero here
        rd_value = dmm_pkg::DATA_ZERO;
      end
    end
    else if (bank_impl(eff_addr))
    begin
      // general ram location
      rd_value = ram_mem[eff_addr];
    end
    else
    begin
      // missing bank returns zero
      rd_value = dmm_pkg::DATA_ZERO;
    end
  end

  // ==========================================================
  // ram write
  // ==========================================================
  // writes to missing banks or register area never reach ram
  assign ram_we = WR_REQ && !dmm_pkg::in_reg_area(eff_addr)
                  && bank_impl(eff_addr);

  // ram has no reset branch so contents survive every reset
  always_ff @(posedge REF_CLK)
  begin
    if (ram_we)
    begin
      ram_mem[eff_addr] <= WR_DATA;
    end
  end

  // ==========================================================
  // next state
  // ==========================================================
  // one pass per cycle; every access finishes in one edge
  always_comb
  begin
    next_st = st;
    // completion pulse also for dropped writes, flags must update
    next_st.done = req;
    if (req)
    begin
      // record address and byte of this access
      next_st.addr = eff_addr;
      next_st.rd_data = rd_value;
    end
    if (WR_REQ && eff_addr == dmm_pkg::BANK_PTR_ADDR)
    begin
      // only the low nibble is kept
      next_st.bank = WR_DATA[3:0];
    end
  end

  // ==========================================================
  // state register
  // ==========================================================
  // asynchronous reset to constants only
  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      st.bank <= dmm_pkg::BANK_RESET;
      st.addr <= dmm_pkg::ADDR_RESET;
      st.rd_data <= dmm_pkg::DATA_RESET;
      st.done <= 1'b0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  // every output is a bare flip-flop
  assign ADDR_OUT = st.addr;
  assign RD_DATA = st.rd_data;
  assign DONE = st.done;
  assign BANK = st.bank;

  // ==========================================================
  // assertions
  // ==========================================================
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!NRST);

  // banked access address
  property p_banked;
    req && WIN_SEL && !FULL_MOVE
      |=> ADDR_OUT == {$past(BANK), $past(OPER_ADDR)};
  endproperty
  a_banked: assert property (p_banked)
    else $error("banked address not pointer and operand");

  // low window offsets land in bank 0 whatever the pointer
  property p_fast_low;
    req && !WIN_SEL && !FULL_MOVE && !EXT_SET_EN
      && OPER_ADDR < dmm_pkg::FAST_SPLIT
      |=> ADDR_OUT[11:8] == 4'h0 && ADDR_OUT[7:0] == $past(OPER_ADDR);
  endproperty
  a_fast_low: assert property (p_fast_low)
    else $error("low window offset not in bank 0");

  // high window offsets land in bank 15
  property p_fast_high;
    req && !WIN_SEL && !FULL_MOVE && !EXT_SET_EN
      && OPER_ADDR >= dmm_pkg::FAST_SPLIT
      |=> ADDR_OUT == {4'hF, $past(OPER_ADDR)};
  endproperty
  a_fast_high: assert property (p_fast_high)
    else $error("high window offset not in bank 15");

  // an access followed by an idle cycle completes at the next edge, then pulse ends
  property p_one_cycle;
    req ##1 !req |-> DONE ##1 !DONE;
  endproperty
  a_one_cycle: assert property (p_one_cycle)
    else $error("access did not complete in one cycle");

  // pointer write keeps low nibble only
  property p_ptr_write;
    WR_REQ && FULL_MOVE && FULL_ADDR == dmm_pkg::BANK_PTR_ADDR
      |=> BANK == $past(WR_DATA[3:0]);
  endproperty
  a_ptr_write: assert property (p_ptr_write)
    else $error("bank pointer write not taken");

  // pointer read shows zero upper nibble and current bank
  property p_ptr_read;
    RD_REQ && !WR_REQ && FULL_MOVE
      && FULL_ADDR == dmm_pkg::BANK_PTR_ADDR
      |=> RD_DATA == {4'h0, $past(BANK)};
  endproperty
  a_ptr_read: assert property (p_ptr_read)
    else $error("bank pointer read wrong");

  // other register locations read zero
  property p_reg_zero;
    RD_REQ && FULL_MOVE && FULL_ADDR >= dmm_pkg::REG_AREA_BASE
      && FULL_ADDR != dmm_pkg::BANK_PTR_ADDR
      |=> RD_DATA == 8'h00;
  endproperty
  a_reg_zero: assert property (p_reg_zero)
    else $error("unused register location not zero");

  // missing bank reads zero but still completes
  property p_missing_bank;
    RD_REQ && FULL_MOVE && FULL_ADDR < dmm_pkg::REG_AREA_BASE
      && {1'b0, FULL_ADDR[11:8]} >= 5'(IMPL_BANKS)
      |=> RD_DATA == 8'h00 && DONE;
  endproperty
  a_missing_bank: assert property (p_missing_bank)
    else $error("missing bank read not zero");

  // full address move bypasses the pointer
  property p_full_move;
    req && FULL_MOVE |=> ADDR_OUT == $past(FULL_ADDR);
  endproperty
  a_full_move: assert property (p_full_move)
    else $error("full move address altered");

  // write, one idle cycle, then read of the same ram byte gives it back;
  // the idle cycle in between rules out a second write to the byte
  property p_ram_back;
    RD_REQ && !WR_REQ && FULL_MOVE && !$past(req)
      && $past(WR_REQ, 2) && !$past(RD_REQ, 2) && $past(FULL_MOVE, 2)
      && FULL_ADDR == $past(FULL_ADDR, 2)
      && FULL_ADDR < dmm_pkg::REG_AREA_BASE && bank_impl(FULL_ADDR)
      |=> RD_DATA == $past(WR_DATA, 3);
  endproperty
  a_ram_back: assert property (p_ram_back)
    else $error("ram byte not read back");

  // extended set hands the window to the external map
  property p_ext_window;
    req && !WIN_SEL && !FULL_MOVE && EXT_SET_EN
      |=> ADDR_OUT == $past(ALT_ADDR);
  endproperty
  a_ext_window: assert property (p_ext_window)
    else $error("extended window address not taken");

  // no pulse and no new address without a request
  property p_idle_quiet;
    !req |=> !DONE && $stable(ADDR_OUT);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("output moved without a request");

  // pointer moves only on a write to its own address, so a stray
  // write elsewhere can never redirect later banked accesses
  property p_ptr_hold;
    !(WR_REQ && eff_addr == dmm_pkg::BANK_PTR_ADDR) |=> $stable(BANK);
  endproperty
  a_ptr_hold: assert property (p_ptr_hold)
    else $error("bank pointer changed without a write");

  // window reads of the register part, pointer aside, give zero
  property p_win_reg_zero;
    RD_REQ && !WIN_SEL && !FULL_MOVE && !EXT_SET_EN
      && OPER_ADDR >= dmm_pkg::FAST_SPLIT
      && {dmm_pkg::FAST_HIGH_BANK, OPER_ADDR} != dmm_pkg::BANK_PTR_ADDR
      |=> RD_DATA == dmm_pkg::DATA_ZERO;
  endproperty
  a_win_reg_zero: assert property (p_win_reg_zero)
    else $error("window register read not zero");

  // main scenarios
  c_fast_low: cover property (req && !WIN_SEL && !FULL_MOVE
    && OPER_ADDR < dmm_pkg::FAST_SPLIT);
  c_fast_high: cover property (req && !WIN_SEL && !FULL_MOVE
    && OPER_ADDR >= dmm_pkg::FAST_SPLIT);
  c_banked: cover property (req && WIN_SEL && BANK != 4'h0);
  c_full: cover property (WR_REQ && FULL_MOVE);
  c_ext: cover property (req && !WIN_SEL && !FULL_MOVE && EXT_SET_EN);

endmodule

// ---- dv/dmm_cpu_model.sv ----
// ==========================================================
// decoder side model: issues one byte access at a time
// ==========================================================
module dmm_cpu_model (
  input wire logic clk,
  input wire logic [11:0] addr_out,
  input wire logic [7:0] rd_data,
  input wire logic done,
  output logic [7:0] oper,
  output logic win_sel,
  output logic full_move,
  output logic [11:0] full_addr,
  output logic ext_en,
  output logic [11:0] alt_addr,
  output logic rd_req,
  output logic wr_req,
  output logic [7:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // quiet bus at time zero
  initial
  begin
    {oper, win_sel, full_move, full_addr} = '0;
    {ext_en, alt_addr, rd_req, wr_req, wr_data} = '0;
  end

  // drive after an edge, hold through the taking edge, then release
  task automatic access(input logic rd, wr, win, full, ext,
                        input logic [7:0] op, wd,
                        input logic [11:0] fa, aa,
                        output logic [11:0] a, output logic [7:0] d,
                        output logic dn);
    @(posedge clk);
    rd_req <= rd;
    wr_req <= wr;
    win_sel <= win;
    full_move <= full;
    ext_en <= ext;
    oper <= op;
    wr_data <= wd;
    full_addr <= fa;
    alt_addr <= aa;
    @(posedge clk);
    rd_req <= 1'b0;
    wr_req <= 1'b0;
    // released lines flip so stale values cannot pass for good ones
    oper <= ~op;
    wr_data <= ~wd;
    full_addr <= ~fa;
    alt_addr <= ~aa;
    @(negedge clk);
    a = addr_out;
    d = rd_data;
    dn = done;
  endtask
endmodule

// ---- dv/testbench.sv ----
// ==========================================================
// self-checking bench for the window mapper
// ==========================================================
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // fewer ram banks so the unimplemented range is reachable
  localparam int IMPL = 8;
  logic REF_CLK, NRST;
  logic [7:0] oper, wr_data, rd_data;
  logic win_sel, full_move, ext_en, rd_req, wr_req, done;
  logic [11:0] full_addr, alt_addr, addr_out;
  logic [3:0] bank, bank_m; // design pointer and expected pointer
  int miscompares, n_compared;
  logic [31:0] seed;
  logic [7:0] shadow [int]; // bytes known to be written

  dmm_window_mapper #(.IMPL_BANKS(IMPL)) dut_u (.REF_CLK(REF_CLK),
    .NRST(NRST), .OPER_ADDR(oper), .WIN_SEL(win_sel),
    .FULL_MOVE(full_move), .FULL_ADDR(full_addr), .EXT_SET_EN(ext_en),
    .ALT_ADDR(alt_addr), .RD_REQ(rd_req), .WR_REQ(wr_req),
    .WR_DATA(wr_data), .ADDR_OUT(addr_out), .RD_DATA(rd_data),
    .DONE(done), .BANK(bank));
  dmm_cpu_model cpu_u (.clk(REF_CLK), .addr_out(addr_out),
    .rd_data(rd_data), .done(done), .oper(oper), .win_sel(win_sel),
    .full_move(full_move), .full_addr(full_addr), .ext_en(ext_en),
    .alt_addr(alt_addr), .rd_req(rd_req), .wr_req(wr_req),
    .wr_data(wr_data));

  initial
  begin
    REF_CLK = 1'b0;
    forever #25 REF_CLK = ~REF_CLK;
  end

  // ==========================================================
  // expectations
  // ==========================================================
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [11:0] exp_addr(input logic win, full, ext,
    input logic [7:0] op, input logic [11:0] fa, aa);
    if (full) return fa;
    if (win) return {bank_m, op};
    if (ext) return aa;
    if (op < dmm_pkg::FAST_SPLIT) return {dmm_pkg::FAST_LOW_BANK, op};
    return {dmm_pkg::FAST_HIGH_BANK, op};
  endfunction

  // unwritten ram is unknown, so no byte is expected there
  function automatic logic [7:0] exp_data(input logic [11:0] ea,
                                          output logic known);
    known = 1'b1;
    if (ea == dmm_pkg::BANK_PTR_ADDR) return {4'h0, bank_m};
    if (ea >= dmm_pkg::REG_AREA_BASE || ea[11:8] >= IMPL) return 8'h00;
    if (shadow.exists(ea)) return shadow[ea];
    known = 1'b0;
    return 8'h00;
  endfunction

  task automatic check(input logic ok, input string what);
    n_compared++;
    if (!ok)
    begin
      miscompares++;
      $display("ERROR t=%0t %s mismatch", $time, what);
    end
  endtask

  // one access through the model, then compare every output, read data only where the byte is known
  task automatic xfer(input logic rd, wr, win, full, ext,
                      input logic [7:0] op, wd, input logic [11:0] fa, aa);
    logic [11:0] a, ea;
    logic [7:0] d, ed;
    logic dn, known;
    ea = exp_addr(win, full, ext, op, fa, aa);
    ed = exp_data(ea, known);
    cpu_u.access(rd, wr, win, full, ext, op, wd, fa, aa, a, d, dn);
    check(a === ea, "address");
    check(dn === 1'b1, "done");
    if (known) check(d === ed, "read data");
    if (wr && ea == dmm_pkg::BANK_PTR_ADDR) bank_m = wd[3:0];
    else if (wr && ea < dmm_pkg::REG_AREA_BASE && ea[11:8] < IMPL)
      shadow[ea] = wd;
    check(bank === bank_m, "bank pointer");
  endtask

  task automatic close_out();
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // watchdog far beyond the expected run length
  initial
  begin
    repeat (20000) @(posedge REF_CLK);
    miscompares++;
    close_out();
  end

  // ==========================================================
  // scenarios
  // ==========================================================
  initial
  begin
    logic [7:0] wins [6];
    wins = '{8'h00, 8'h5F, 8'h60, 8'hFF, 8'h20, 8'h70};
    NRST = 1'b0;
    seed = 32'h00015961; // 88417
    bank_m = 4'h0;
    miscompares = 0;
    n_compared = 0;
    repeat (5) @(posedge REF_CLK);
    NRST <= 1'b1;
    @(negedge REF_CLK);
    check(bank === 4'h0 && addr_out === 12'h000 && done === 1'b0
          && rd_data === 8'h00, "reset");
    xfer(0, 1, 0, 1, 0, 8'h00, 8'hA5, 12'hFE0, 12'h000);
    xfer(1, 0, 0, 1, 0, 8'h00, 8'h00, 12'hFE0, 12'h000);
    $display("test pointer done");
    foreach (wins[i])
    begin
      xfer(0, 1, 0, 0, 0, wins[i], ~wins[i], 12'h3C3, 12'h000);
      xfer(1, 0, 0, 0, 0, wins[i], 8'h00, 12'h3C3, 12'h000);
    end
    $display("test fast window done");
    for (int b = 0; b < 16; b++)
    begin
      xfer(0, 1, 0, 1, 0, 8'h00, 8'hA0 | b[7:0], 12'hFE0, 12'h0);
      xfer(0, 1, 1, 0, 0, 8'h34, 8'h11 + b[7:0], 12'h0, 12'h0);
      xfer(1, 0, 1, 0, 0, 8'h34, 8'h00, 12'h0, 12'h0);
    end
    xfer(0, 1, 0, 1, 0, 8'h00, 8'h5A, 12'hEF8, 12'h0);
    xfer(1, 0, 0, 1, 0, 8'h00, 8'h00, 12'hEF8, 12'h0);
    xfer(0, 1, 0, 1, 0, 8'h00, 8'h5C, 12'h123, 12'h0);
    xfer(1, 0, 0, 1, 0, 8'h00, 8'h00, 12'h123, 12'h0);
    xfer(1, 1, 0, 1, 0, 8'h00, 8'h77, 12'h134, 12'h0);
    xfer(1, 0, 0, 0, 1, 8'h10, 8'h00, 12'h0, 12'h123);
    $display("test banks done");
    xfer(0, 1, 0, 1, 0, 8'h00, 8'h3C, 12'h000, 12'h0);
    @(posedge REF_CLK);
    NRST <= 1'b0;
    repeat (3) @(posedge REF_CLK);
    NRST <= 1'b1;
    bank_m = 4'h0;
    xfer(1, 0, 0, 1, 0, 8'h00, 8'h00, 12'h000, 12'h0);
    $display("test reset keeps ram done");
    repeat (200)
    begin
      seed = lfsr_next(seed);
      xfer(seed[0], ~seed[0], seed[1], seed[2] & seed[3], seed[4],
           seed[12:5], seed[20:13], seed[31:20], seed[11:0]);
    end
    $display("test random done");
    close_out();
  end
endmodule
